// ===== hw/iri_maskable_irq_in_inputs.sv
// Maskable and non-maskable interrupt request recognition with acknowledge sequencing
`timescale 1ns/1ns
module iri_maskable_irq_in_inputs
  import iri_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic maskable_irq_in,
  input  wire logic nmiIn,
  input  wire logic intEnable,
  input  wire logic atBoundary,
  input  wire logic ackCycleDone,
  output logic      ackCycleReq,
  output logic      ackLock,
  output logic      ackFirst,
  output logic      maskableTaken,
  output logic      nmiPending,
  output logic      nmiTaken,
  output logic      nmiEarlyEdge
);

  logic           irqSync;
  logic           nmiSync;
  logic           nmiSyncQ;
  logic           nmiRise;
  logic [2:0]     lowCount;
  logic [1:0]     ackCount;
  iri_ack_state_t state;
  logic           startNmi;
  logic           startIrq;

  // Both asynchronous requests pass two flip-flops
  iri_sync2 u_irqSync (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .asyncIn (maskable_irq_in),
    .syncOut (irqSync)
  );

  iri_sync2 u_nmiSync (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .asyncIn (nmiIn),
    .syncOut (nmiSync)
  );

  // Delayed copy of synchronised non-maskable level for edge detection
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      nmiSyncQ <= 1'b1;
    end else begin
      nmiSyncQ <= nmiSync;
    end
  end

  assign nmiRise = nmiSync && !nmiSyncQ;

  // Count low cycles before an edge to flag short low periods
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      lowCount <= IRI_LOWCNT_RST;
    end else if (nmiSync) begin
      lowCount <= IRI_LOWCNT_RST;
    end else if (lowCount != IRI_LOWCNT_MAX) begin
      lowCount <= lowCount + 3'h1;
    end
  end

  // Sticky warning when the requester breaks the low-time minimum
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      nmiEarlyEdge <= 1'b0;
    end else if (nmiRise && ({29'h0, lowCount} < IRI_NMI_LOW_MIN)) begin
      nmiEarlyEdge <= 1'b1;
    end
  end

  // Service arbitration: non-maskable wins and is not gated by the enable
  assign startNmi = atBoundary && nmiPending && (state == IRI_IDLE);
  assign startIrq = atBoundary && !nmiPending && irqSync && intEnable && (state == IRI_IDLE);

  // Pending non-maskable edge; a new edge wins over the service clear
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      nmiPending <= 1'b0;
    end else if (nmiRise) begin
      nmiPending <= 1'b1;
    end else if (startNmi) begin
      nmiPending <= 1'b0;
    end
  end

  // One-cycle service strobes
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      nmiTaken      <= 1'b0;
      maskableTaken <= 1'b0;
    end else begin
      nmiTaken      <= startNmi;
      maskableTaken <= startIrq;
    end
  end

  // Acknowledge sequencer: two acknowledge cycles held under lock
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state    <= IRI_IDLE;
      ackCount <= 2'h0;
    end else begin
      unique case (state)
        IRI_IDLE: begin
          if (startIrq) begin
            state    <= IRI_ACK;
            ackCount <= 2'h0;
          end
        end
        IRI_ACK: begin
          if (ackCycleDone) begin
            ackCount <= ackCount + 2'h1;
            if (ackCount + 2'h1 == IRI_ACK_CYCLES) begin
              state <= IRI_WAIT;
            end
          end
        end
        IRI_WAIT: begin
          state <= IRI_IDLE;
        end
      endcase
    end
  end

  // Requests and lock towards the bus unit
  assign ackCycleReq = (state == IRI_ACK);
  assign ackLock     = (state == IRI_ACK);
  assign ackFirst    = (state == IRI_ACK) && (ackCount == 2'h0);

  // Assertions
  property p_irq_gate;
    @(posedge mclk) disable iff (!rst_b) maskableTaken |-> $past(intEnable) && $past(irqSync);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("maskable taken without enable");

  property p_two_acks;
    @(posedge mclk) disable iff (!rst_b)
      (ackCycleReq && ackCycleDone && !ackFirst) |=> !ackCycleReq;
  endproperty
  a_two_acks: assert property (p_two_acks) else $error("more than two acknowledges");

  property p_lock_cover;
    @(posedge mclk) disable iff (!rst_b) ackCycleReq |-> ackLock;
  endproperty
  a_lock_cover: assert property (p_lock_cover) else $error("acknowledge without lock");

  property p_start_ack;
    @(posedge mclk) disable iff (!rst_b) maskableTaken |-> ackCycleReq && ackFirst;
  endproperty
  a_start_ack: assert property (p_start_ack) else $error("acknowledge sequence missing");

  property p_sync_delay;
    @(posedge mclk) disable iff (!rst_b) $rose(irqSync) |-> $past(maskable_irq_in, 2);
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("maskable sync depth wrong");

  property p_nmi_ungated;
    @(posedge mclk) disable iff (!rst_b)
      (nmiPending && atBoundary && (state == IRI_IDLE)) |=> nmiTaken;
  endproperty
  a_nmi_ungated: assert property (p_nmi_ungated) else $error("non-maskable not serviced");

  property p_nmi_edge;
    @(posedge mclk) disable iff (!rst_b) $rose(nmiPending) |-> $past(nmiSync) && !$past(nmiSyncQ);
  endproperty
  a_nmi_edge: assert property (p_nmi_edge) else $error("pending without rising edge");

  property p_nmi_hold;
    @(posedge mclk) disable iff (!rst_b) (nmiPending && !$past(startNmi)) |-> $past(nmiPending) || $past(nmiRise);
  endproperty
  a_nmi_hold: assert property (p_nmi_hold) else $error("pending set without cause");

  property p_nmi_keep;
    @(posedge mclk) disable iff (!rst_b) (nmiPending && !startNmi) |=> nmiPending;
  endproperty
  a_nmi_keep: assert property (p_nmi_keep) else $error("pending lost before service");

  property p_nmi_sync;
    @(posedge mclk) disable iff (!rst_b) $rose(nmiSync) |-> $past(nmiIn, 2);
  endproperty
  a_nmi_sync: assert property (p_nmi_sync) else $error("non-maskable sync depth wrong");

  // Lock stays up between the two acknowledges of one pair
  property p_ack_pair;
    @(posedge mclk) disable iff (!rst_b)
      (ackFirst && ackCycleDone) |=> (ackCycleReq && ackLock && !ackFirst);
  endproperty
  a_ack_pair: assert property (p_ack_pair) else $error("lock dropped between acknowledges");

  // Starting service drops the pending edge unless a new edge arrives
  property p_nmi_clear;
    @(posedge mclk) disable iff (!rst_b) (startNmi && !nmiRise) |=> !nmiPending;
  endproperty
  a_nmi_clear: assert property (p_nmi_clear) else $error("pending kept after service");

  // A pending non-maskable request blocks maskable service at a boundary
  property p_nmi_first;
    @(posedge mclk) disable iff (!rst_b) (nmiPending && atBoundary) |=> !maskableTaken;
  endproperty
  a_nmi_first: assert property (p_nmi_first) else $error("maskable served before non-maskable");

  // Warning only follows an edge seen after a short low time
  property p_early_flag;
    @(posedge mclk) disable iff (!rst_b)
      $rose(nmiEarlyEdge) |-> $past(nmiRise) && ({29'h0, $past(lowCount)} < IRI_NMI_LOW_MIN);
  endproperty
  a_early_flag: assert property (p_early_flag) else $error("low-time warning without short low");

  c_irq:   cover property (@(posedge mclk) disable iff (!rst_b) maskableTaken ##[1:20] (state == IRI_WAIT));
  c_nmi:   cover property (@(posedge mclk) disable iff (!rst_b) nmiRise ##[1:10] nmiTaken);
  c_early: cover property (@(posedge mclk) disable iff (!rst_b) $rose(nmiEarlyEdge));
  c_prio:  cover property (@(posedge mclk) disable iff (!rst_b) nmiTaken ##1 maskableTaken);

endmodule

// ===== hw/iri_pkg.sv
// Package of constants and types for the interrupt request input block
package iri_pkg;

  // Number of interrupt-acknowledge cycles per maskable request
  localparam logic [1:0] IRI_ACK_CYCLES   = 2'h2;
  // Least low time before a non-maskable rising edge, in clock periods
  localparam int         IRI_NMI_LOW_MIN  = 4;
  // Width of the low-time counter
  localparam int         IRI_LOWCNT_W     = 3;
  localparam logic [2:0] IRI_LOWCNT_MAX   = 3'h7;
  localparam logic [2:0] IRI_LOWCNT_RST   = 3'h0;

  // Acknowledge sequencer states
  typedef enum logic [1:0] {
    IRI_IDLE,
    IRI_ACK,
    IRI_WAIT
  } iri_ack_state_t;

endpackage

// ===== hw/iri_sync2.sv
// Two-flop synchroniser for one asynchronous level
`timescale 1ns/1ns
module iri_sync2
  import iri_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic asyncIn,
  output logic      syncOut
);

  logic stage1;

  // First stage feeds only the second stage
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      stage1  <= 1'b0;
      syncOut <= 1'b0;
    end else begin
      stage1  <= asyncIn;
      syncOut <= stage1;
    end
  end

endmodule

// ===== test/iri_irq_source.sv
// Model of the external interrupt controller driving both request lines
`timescale 1ns/1ns
module iri_irq_source (
  input  wire logic mclk,
  input  wire logic ackCycleDone,
  output logic      maskable_irq_in,
  output logic      nmiIn
);
  int doneCount;
  // Both lines idle low from time zero
  initial begin
    maskable_irq_in = 1'b0;
    nmiIn = 1'b0;
  end
  // Raise the maskable line and hold it through both acknowledges
  task automatic requestMaskable();
    @(posedge mclk) maskable_irq_in <= 1'b1;
    doneCount = 0;
    while (doneCount < 2) begin
      @(posedge mclk);
      if (ackCycleDone === 1'b1) doneCount++;
    end
    maskable_irq_in <= 1'b0;
  endtask
  // Low for lowCycles periods, then a rising edge held six periods
  task automatic fireNmi(input int lowCycles);
    @(posedge mclk) nmiIn <= 1'b0;
    repeat (lowCycles) @(posedge mclk);
    nmiIn <= 1'b1;
    repeat (6) @(posedge mclk);
    nmiIn <= 1'b0;
  endtask
endmodule

// ===== test/iri_maskable_irq_in_inputs_tb.sv
// Self-checking bench for the interrupt request input block
`timescale 1ns/1ns
module iri_maskable_irq_in_inputs_tb;
  import iri_pkg::*;
  logic mclk, rst_b, maskable_irq_in, nmiIn, intEnable, atBoundary, ackCycleDone;
  logic ackCycleReq, ackLock, ackFirst, maskableTaken, nmiPending, nmiTaken, nmiEarlyEdge;
  int num_errors, checked, cycles;
  logic [1:0] expQ[$];
  iri_maskable_irq_in_inputs iri_maskable_irq_in_inputs_i (.mclk, .rst_b, .maskable_irq_in, .nmiIn, .intEnable,
    .atBoundary, .ackCycleDone, .ackCycleReq, .ackLock, .ackFirst, .maskableTaken,
    .nmiPending, .nmiTaken, .nmiEarlyEdge);
  iri_irq_source iri_irq_source_i (.mclk, .ackCycleDone, .maskable_irq_in, .nmiIn);
  // Clock and cycle ceiling
  always #25 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      summarize();
    end
  end
  task automatic check(input string name, input logic [1:0] seen, input logic [1:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("errors %0d checked %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Serve one acknowledge pair as the bus unit would
  task automatic ackPair();
    int n;
    n = 0;
    while (ackCycleReq !== 1'b1 && n < 20) begin
      @(posedge mclk);
      #1;
      n++;
    end
    check("lockFirst", {ackLock, ackFirst}, 2'h3);
    check("reqLock", {ackCycleReq, ackLock}, 2'h3);
    for (int i = 0; i < 2; i++) begin
      @(posedge mclk) ackCycleDone <= 1'b1;
      @(posedge mclk) ackCycleDone <= 1'b0;
      #1;
      check("lockFirst", {ackLock, ackFirst}, i == 0 ? 2'h2 : 2'h0);
      check("reqLock", {ackCycleReq, ackLock}, i == 0 ? 2'h3 : 2'h0);
    end
    @(posedge mclk) intEnable <= 1'b0;
  endtask
  // Every service pulse takes the oldest expected event
  always @(posedge mclk) begin
    #1;
    if (rst_b === 1'b1 && (maskableTaken !== 1'b0 || nmiTaken !== 1'b0)) begin
      if (expQ.size() == 0) check("event", {nmiTaken, maskableTaken}, 2'h0);
      else check("event", {nmiTaken, maskableTaken}, expQ.pop_front());
    end
  end
  initial begin
    mclk = 1'b0;
    rst_b = 1'b0;
    intEnable = 1'b0;
    atBoundary = 1'b1;
    ackCycleDone = 1'b0;
    void'($urandom(51970));
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    // Maskable held while disabled, then served once enabled
    fork
      iri_irq_source_i.requestMaskable();
      begin
        repeat (8 + $urandom_range(4)) @(posedge mclk);
        expQ.push_back(2'h1);
        intEnable <= 1'b1;
        ackPair();
      end
    join
    // Non-maskable with the flag clear, kept pending off boundary
    @(posedge mclk) atBoundary <= 1'b0;
    iri_irq_source_i.fireNmi(4 + $urandom_range(3));
    repeat (4) @(posedge mclk);
    #1;
    check("pending", {1'b0, nmiPending}, 2'h1);
    @(posedge mclk) atBoundary <= 1'b1;
    expQ.push_back(2'h2);
    repeat (20) @(posedge mclk);
    // Short low time flagged, then reset clears everything
    atBoundary <= 1'b0;
    iri_irq_source_i.fireNmi(5);
    iri_irq_source_i.fireNmi(2);
    #1;
    check("earlyPend", {nmiEarlyEdge, nmiPending}, 2'h3);
    @(posedge mclk) rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    #1;
    check("earlyPend", {nmiEarlyEdge, nmiPending}, 2'h0);
    // Both requests pending at a boundary: non-maskable served first
    fork
      iri_irq_source_i.requestMaskable();
      iri_irq_source_i.fireNmi(4);
      begin
        repeat (8) @(posedge mclk);
        expQ.push_back(2'h2);
        expQ.push_back(2'h1);
        intEnable <= 1'b1;
        atBoundary <= 1'b1;
        ackPair();
      end
    join
    repeat (10) @(posedge mclk);
    check("queue", expQ.size() == 0 ? 2'h0 : 2'h3, 2'h0);
    summarize();
  end
endmodule
